/* include/lrs_map.svh */
// register offsets, bit positions, reset values and timing counts
`ifndef LRS_MAP_SVH
`define LRS_MAP_SVH
`define LRS_OFF_STATUS 4'h0
`define LRS_OFF_MASK 4'h1
`define LRS_OFF_DMA_CTRL 4'h2
`define LRS_OFF_CONFIG 4'h3
`define LRS_OFF_BUF_STAT 4'h4
`define LRS_BIT_PACKET_READY_FLAG 7
`define LRS_BIT_RD_ERR 6
`define LRS_BIT_DMA_DONE 5
`define LRS_BIT_REMOTE_RESET_FLAG 4
`define LRS_BIT_SHORT 3
`define LRS_BIT_ALIGN 2
`define LRS_BIT_CRC 1
`define LRS_BIT_OVR 0
`define LRS_BIT_RX_DMA_EN 0
`define LRS_BIT_TX_DMA_EN 1
`define LRS_BIT_PC_CARD 0
`define LRS_RST_STATUS 8'h00
`define LRS_RST_MASK 8'h00
`define LRS_RST_DMA_CTRL 8'h00
`define LRS_RST_CONFIG 8'h00
`define LRS_RDY_TIMEOUT_NS 2150
`define LRS_CLK_PERIOD_NS 40
// longest time rounds down: 2150/40 = 53 cycles
`define LRS_RDY_TIMEOUT_CYC (`LRS_RDY_TIMEOUT_NS / `LRS_CLK_PERIOD_NS)
`endif

/* include/lrs_pkg.sv */
// types shared by the receive status block
package lrs_pkg;
	typedef logic [7:0] lrs_byte_t;
	typedef enum logic [1:0] {
		LRS_RD_IDLE = 2'b00,
		LRS_RD_WAIT = 2'b01,
		LRS_RD_DONE = 2'b10
	} lrs_rd_state_t;
endpackage

/* include/lrs_evt_if.sv */
// event and clear signals between the status core and its flag bank
`timescale 1ns/1ps
interface lrs_evt_if;
	logic [7:0] set_evt;
	logic [7:0] clr_w1c;
	logic [7:0] clr_hw;
	logic [7:0] flags;
	modport core (output set_evt, output clr_w1c, output clr_hw, input flags);
	modport bank (input set_evt, input clr_w1c, input clr_hw, output flags);
endinterface

/* hw/lrs_flag_bank.sv */
// sticky flag bank: set wins over any clear in the same cycle
`timescale 1ns/1ps
`include "lrs_map.svh"
module lrs_flag_bank (
	input wire logic clk,
	input wire logic arst_n,
	lrs_evt_if.bank evt
);
	logic [7:0] flags_r;
	logic [7:0] flags_nxt;

	assign flags_nxt = evt.set_evt | (flags_r & ~(evt.clr_w1c | evt.clr_hw));
	assign evt.flags = flags_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_r <= `LRS_RST_STATUS;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	property p_set_wins;
		@(posedge clk) disable iff (!arst_n)
		|evt.set_evt |=> ((flags_r & $past(evt.set_evt)) == $past(evt.set_evt));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("set event lost");

	property p_w1c_clears;
		@(posedge clk) disable iff (!arst_n)
		(|(evt.clr_w1c & ~evt.set_evt & flags_r)) |=>
			((flags_r & $past(evt.clr_w1c & ~evt.set_evt)) == 8'h00);
	endproperty
	a_w1c_clears: assert property (p_w1c_clears) else $error("w1c failed");
endmodule

/* hw/lrs_receive_status.sv */
// receive status register block with mask, dma control and buffer read check
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "lrs_map.svh"
module lrs_receive_status (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] pkt_count,
	input wire logic pkt_read_done,
	input wire logic buf_rd_req,
	input wire logic buf_data_avail,
	output logic buf_rdy,
	input wire logic dma_active,
	input wire logic dma_done_flag,
	input wire logic remote_reset_flag_evt,
	input wire logic rx_start,
	input wire logic short_evt,
	input wire logic align_evt,
	input wire logic crc_evt,
	input wire logic overrun_evt,
	output logic irq
);
	// ****************************************************************
	// functions
	// ****************************************************************
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	// ****************************************************************
	// register port decode
	// ****************************************************************
	lrs_evt_if evt ();
	lrs_pkg::lrs_byte_t mask_r;
	lrs_pkg::lrs_byte_t dma_ctrl_r;
	lrs_pkg::lrs_byte_t config_r;
	lrs_pkg::lrs_byte_t rdata_r;
	lrs_pkg::lrs_byte_t rdata_nxt;
	wire wr_status = reg_wr && hit(reg_addr, `LRS_OFF_STATUS);
	wire wr_mask = reg_wr && hit(reg_addr, `LRS_OFF_MASK);
	wire wr_dma = reg_wr && hit(reg_addr, `LRS_OFF_DMA_CTRL);
	wire wr_cfg = reg_wr && hit(reg_addr, `LRS_OFF_CONFIG);
	wire pc_card = config_r[`LRS_BIT_PC_CARD];
	wire dma_both_off = !dma_ctrl_r[`LRS_BIT_RX_DMA_EN] &&
		!dma_ctrl_r[`LRS_BIT_TX_DMA_EN];
	wire [7:0] status_view;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_r <= `LRS_RST_MASK;
			dma_ctrl_r <= `LRS_RST_DMA_CTRL;
			config_r <= `LRS_RST_CONFIG;
		end else begin
			if (wr_mask)
				mask_r <= reg_wdata;
			if (wr_dma)
				dma_ctrl_r <= reg_wdata;
			if (wr_cfg)
				config_r <= reg_wdata;
		end
	end

	// ****************************************************************
	// buffer read handshake and timeout
	// ****************************************************************
	// ready is withheld while the buffer is empty; the timeout then flags
	lrs_pkg::lrs_rd_state_t rd_state_r;
	lrs_pkg::lrs_rd_state_t rd_state_nxt;
	logic [5:0] rd_cnt_r;
	logic [5:0] rd_cnt_nxt;
	logic rd_err_pulse;
	localparam logic [5:0] RD_LIMIT = 6'(`LRS_RDY_TIMEOUT_CYC);

	always_comb begin
		rd_state_nxt = rd_state_r;
		rd_cnt_nxt = rd_cnt_r;
		rd_err_pulse = 1'b0;
		case (rd_state_r)
		lrs_pkg::LRS_RD_IDLE: begin
			if (buf_rd_req && !buf_data_avail) begin
				rd_state_nxt = lrs_pkg::LRS_RD_WAIT;
				rd_cnt_nxt = 6'h01;
			end
		end
		lrs_pkg::LRS_RD_WAIT: begin
			if (buf_data_avail || !buf_rd_req) begin
				rd_state_nxt = lrs_pkg::LRS_RD_IDLE;
				rd_cnt_nxt = 6'h00;
			end else if (rd_cnt_r >= RD_LIMIT) begin
				rd_err_pulse = 1'b1;
				rd_state_nxt = lrs_pkg::LRS_RD_DONE;
			end else begin
				rd_cnt_nxt = rd_cnt_r + 6'h01;
			end
		end
		lrs_pkg::LRS_RD_DONE: begin
			// one error per stalled read; wait for the host to let go
			if (!buf_rd_req) begin
				rd_state_nxt = lrs_pkg::LRS_RD_IDLE;
				rd_cnt_nxt = 6'h00;
			end
		end
		default: begin
			rd_state_nxt = lrs_pkg::LRS_RD_IDLE;
			rd_cnt_nxt = 6'h00;
		end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_state_r <= lrs_pkg::LRS_RD_IDLE;
			rd_cnt_r <= 6'h00;
		end else begin
			rd_state_r <= rd_state_nxt;
			rd_cnt_r <= rd_cnt_nxt;
		end
	end

	assign buf_rdy = buf_rd_req && buf_data_avail;

	// ****************************************************************
	// flag events
	// ****************************************************************
	wire pkt_avail = (pkt_count != 8'h00);
	logic pkt_avail_d_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			pkt_avail_d_r <= 1'b0;
		else
			pkt_avail_d_r <= pkt_avail;
	end
	// sets on arrival of the first packet, and again after each read-out that leaves packets in the buffer
	wire pkt_set = pkt_avail && (!pkt_avail_d_r || pkt_read_done);
	wire dma_set = dma_done_flag && !dma_active && !pc_card;

	assign evt.set_evt = {pkt_set, rd_err_pulse, dma_set, remote_reset_flag_evt,
		short_evt, align_evt, crc_evt, overrun_evt};
	assign evt.clr_w1c = wr_status ? reg_wdata : 8'h00;
	assign evt.clr_hw = {!pkt_avail, 1'b0,
		(dma_both_off || dma_active), rx_start && !remote_reset_flag_evt,
		4'h0};

	lrs_flag_bank u_bank (
		.clk(clk),
		.arst_n(arst_n),
		.evt(evt)
	);

	// dma done is masked from view when the host runs in pc card mode
	assign status_view = {evt.flags[7:6], evt.flags[5] & !pc_card,
		evt.flags[4:0]};

	// ****************************************************************
	// read port and interrupt
	// ****************************************************************
	always_comb begin
		if (hit(reg_addr, `LRS_OFF_STATUS))
			rdata_nxt = status_view;
		else if (hit(reg_addr, `LRS_OFF_MASK))
			rdata_nxt = mask_r;
		else if (hit(reg_addr, `LRS_OFF_DMA_CTRL))
			rdata_nxt = dma_ctrl_r;
		else if (hit(reg_addr, `LRS_OFF_CONFIG))
			rdata_nxt = config_r;
		else if (hit(reg_addr, `LRS_OFF_BUF_STAT))
			rdata_nxt = pkt_count;
		else
			rdata_nxt = 8'h00;
	end

	logic irq_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 8'h00;
			irq_r <= 1'b0;
		end else begin
			rdata_r <= reg_rd ? rdata_nxt : 8'h00;
			irq_r <= |(status_view & mask_r);
		end
	end
	assign reg_rdata = rdata_r;
	assign irq = irq_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_irq_level;
		@(posedge clk) disable iff (!arst_n)
		(|(status_view & mask_r)) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq missing");

	property p_irq_drop;
		@(posedge clk) disable iff (!arst_n)
		!(|(status_view & mask_r)) |=> !irq;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("irq stuck");

	property p_pkt_empty;
		@(posedge clk) disable iff (!arst_n)
		(pkt_count == 8'h00) |=> !evt.flags[`LRS_BIT_PACKET_READY_FLAG];
	endproperty
	a_pkt_empty: assert property (p_pkt_empty) else $error("ready w/o pkt");

	property p_pkt_reset;
		@(posedge clk) disable iff (!arst_n)
		(pkt_read_done && pkt_count != 8'h00) |=> evt.flags[`LRS_BIT_PACKET_READY_FLAG];
	endproperty
	a_pkt_reset: assert property (p_pkt_reset) else $error("no re-set");

	property p_rd_timeout;
		@(posedge clk) disable iff (!arst_n)
		(rd_state_r == lrs_pkg::LRS_RD_IDLE && buf_rd_req && !buf_data_avail)
		##1 (buf_rd_req && !buf_data_avail)[*8] |-> ##[0:50]
			(evt.flags[`LRS_BIT_RD_ERR] || !buf_rd_req || buf_data_avail);
	endproperty
	a_rd_timeout: assert property (p_rd_timeout) else $error("no rd err");

	// stall age kept apart from the fsm counter, so the limit is judged
	// against elapsed cycles rather than against the logic it guards
	localparam logic [6:0] STALL_AT_ERR = 7'(`LRS_RDY_TIMEOUT_CYC);
	logic [6:0] stall_age_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			stall_age_r <= 7'h00;
		else if (!buf_rd_req || buf_data_avail)
			stall_age_r <= 7'h00;
		else if (stall_age_r != 7'h7F)
			stall_age_r <= stall_age_r + 7'h01;
	end

	property p_rd_on_time;
		@(posedge clk) disable iff (!arst_n)
		(stall_age_r == STALL_AT_ERR && buf_rd_req && !buf_data_avail) |=>
			evt.flags[`LRS_BIT_RD_ERR];
	endproperty
	a_rd_on_time: assert property (p_rd_on_time) else $error("rd err late");

	property p_rd_not_early;
		@(posedge clk) disable iff (!arst_n)
		rd_err_pulse |-> (stall_age_r == STALL_AT_ERR);
	endproperty
	a_rd_not_early: assert property (p_rd_not_early) else $error("rd err early");

	property p_rdy_empty;
		@(posedge clk) disable iff (!arst_n)
		!buf_data_avail |-> !buf_rdy;
	endproperty
	a_rdy_empty: assert property (p_rdy_empty) else $error("ready on empty");

	property p_dma_set;
		@(posedge clk) disable iff (!arst_n)
		(dma_done_flag && !dma_active && !pc_card) |=> evt.flags[`LRS_BIT_DMA_DONE];
	endproperty
	a_dma_set: assert property (p_dma_set) else $error("dma done lost");

	property p_dma_busy;
		@(posedge clk) disable iff (!arst_n)
		(dma_active && !dma_done_flag) |=> !evt.flags[`LRS_BIT_DMA_DONE];
	endproperty
	a_dma_busy: assert property (p_dma_busy) else $error("dma early");

	property p_dma_off;
		@(posedge clk) disable iff (!arst_n)
		(dma_both_off && !dma_set) |=> !evt.flags[`LRS_BIT_DMA_DONE];
	endproperty
	a_dma_off: assert property (p_dma_off) else $error("dma not cleared");

	property p_rmt_clear;
		@(posedge clk) disable iff (!arst_n)
		(rx_start && !remote_reset_flag_evt) |=> !evt.flags[`LRS_BIT_REMOTE_RESET_FLAG];
	endproperty
	a_rmt_clear: assert property (p_rmt_clear) else $error("rmt kept");

	property p_pc_hide;
		@(posedge clk) disable iff (!arst_n)
		pc_card |-> !status_view[`LRS_BIT_DMA_DONE];
	endproperty
	a_pc_hide: assert property (p_pc_hide) else $error("dma seen");

	c_irq: cover property (@(posedge clk) disable iff (!arst_n) $rose(irq));
	c_rd_err: cover property (@(posedge clk) disable iff (!arst_n)
		rd_err_pulse);
	c_pkt_again: cover property (@(posedge clk) disable iff (!arst_n)
		pkt_read_done && pkt_count != 8'h00);
	c_dma: cover property (@(posedge clk) disable iff (!arst_n) dma_set);
endmodule

/* testbench/lrs_dma_model.sv */
// behavioural model of the external dma controller
`timescale 1ns/1ps
module lrs_dma_model #(
	parameter int LEN = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic start,
	output logic dma_active,
	output logic dma_done_flag
);
	int cnt;
	// ****
	// transfer engine
	// ****
	// end-of-process only after the last beat, once active has dropped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 0;
			dma_active <= 1'b0;
			dma_done_flag <= 1'b0;
		end else begin
			dma_done_flag <= dma_active && cnt == 1;
			if (start) begin
				dma_active <= 1'b1;
				cnt <= LEN;
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
				dma_active <= cnt > 1;
			end
		end
	end
endmodule

/* testbench/lrs_receive_status_tb.sv */
// self-checking bench for the receive status block
`timescale 1ns/1ps
module lrs_receive_status_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] a = 4'h0;
	logic [7:0] wd = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdat;
	logic [7:0] pc = 8'h00;
	logic prd = 1'b0;
	logic breq = 1'b0;
	logic bav = 1'b0;
	logic brdy;
	logic dgo = 1'b0;
	logic dact;
	logic deop;
	logic rxs = 1'b0;
	logic [4:0] ev = 5'h00;
	logic irq;
	logic [7:0] got;
	logic [7:0] r;
	int m = 0;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #20 clk = ~clk;
	lrs_receive_status i_lrs_receive_status (.clk(clk), .arst_n(arst_n),
		.reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdat), .pkt_count(pc), .pkt_read_done(prd),
		.buf_rd_req(breq), .buf_data_avail(bav), .buf_rdy(brdy),
		.dma_active(dact), .dma_done_flag(deop), .remote_reset_flag_evt(ev[4]),
		.rx_start(rxs), .short_evt(ev[3]), .align_evt(ev[2]),
		.crc_evt(ev[1]), .overrun_evt(ev[0]), .irq(irq));
	lrs_dma_model i_lrs_dma_model (.clk(clk), .arst_n(arst_n),
		.start(dgo), .dma_active(dact), .dma_done_flag(deop));
	// ****
	// shared tasks
	// ****
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk);
		a <= ad;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] ad);
		@(posedge clk);
		a <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		got = rdat;
	endtask
	// status read compared with the bench model
	task automatic cst(input string n);
		rreg(4'h0);
		chk(n, m[7:0], got);
	endtask
	task automatic pulse(input logic [4:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 5'h00;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	// ****
	// main sequence
	// ****
	initial begin
		void'($urandom(55));
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		cst("reset status");
		rreg(4'hF);
		chk("unmapped", 8'h00, got);
		tk(1);
		chk("rdata idle", 8'h00, rdat);
		for (int i = 0; i < 5; i++) begin
			pulse(5'h01 << i);
			m = m | (1 << i);
			cst("event flag");
		end
		repeat (4) begin
			r = 8'($urandom);
			wreg(4'h0, r);
			m = m & ~int'(r);
			cst("w1c");
			pulse(5'h1F);
			m = m | 8'h1F;
		end
		wreg(4'h0, 8'hFF);
		m = 0;
		$display("test flags done");
		wreg(4'h1, 8'h01);
		pulse(5'h02);
		tk(2);
		chk("irq masked", 8'h00, {7'h00, irq});
		pulse(5'h01);
		tk(2);
		chk("irq", 8'h01, {7'h00, irq});
		wreg(4'h0, 8'h01);
		tk(1);
		chk("irq drop", 8'h00, {7'h00, irq});
		wreg(4'h0, 8'h02);
		pulse(5'h10);
		m = 8'h10;
		cst("remote");
		@(posedge clk);
		rxs <= 1'b1;
		@(posedge clk);
		rxs <= 1'b0;
		m = 0;
		cst("remote auto");
		$display("test irq done");
		@(posedge clk);
		pc <= 8'h02;
		m = 8'h80;
		tk(2);
		cst("ready");
		wreg(4'h0, 8'h80);
		m = 0;
		cst("ready w1c");
		@(posedge clk);
		pc <= 8'h01;
		prd <= 1'b1;
		@(posedge clk);
		prd <= 1'b0;
		m = 8'h80;
		cst("ready again");
		rreg(4'h4);
		chk("count", 8'h01, got);
		@(posedge clk);
		pc <= 8'h00;
		m = 0;
		tk(1);
		cst("ready empty");
		$display("test ready done");
		@(posedge clk);
		breq <= 1'b1;
		bav <= 1'b1;
		tk(60);
		chk("buf ready", 8'h01, {7'h00, brdy});
		@(posedge clk);
		bav <= 1'b0;
		breq <= 1'b0;
		cst("no error");
		@(posedge clk);
		breq <= 1'b1;
		tk(48);
		cst("early");
		tk(10);
		chk("stalled", 8'h00, {7'h00, brdy});
		m = 8'h40;
		cst("read error");
		@(posedge clk);
		breq <= 1'b0;
		wreg(4'h0, 8'h40);
		m = 0;
		$display("test read error done");
		wreg(4'h2, 8'h01);
		@(posedge clk);
		dgo <= 1'b1;
		@(posedge clk);
		dgo <= 1'b0;
		tk(2);
		cst("dma busy");
		tk(12);
		m = 8'h20;
		cst("dma done");
		wreg(4'h2, 8'h00);
		m = 0;
		cst("dma off");
		wreg(4'h3, 8'h01);
		wreg(4'h2, 8'h03);
		@(posedge clk);
		dgo <= 1'b1;
		@(posedge clk);
		dgo <= 1'b0;
		tk(14);
		cst("pc card");
		$display("test dma done");
		tally_and_finish();
	end
endmodule
